// ### src/mac_tx_timing_config.sv
// MAC transmit timing configuration: register bank, symbol tick generator,
// acknowledgement wait timer, slot decode and transmit/amplifier lead enables.
// Assumes all control inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module mac_tx_timing_config #(
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Avalon-MM register slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// MAC sequencing inputs
	input wire logic tx_request,
	input wire logic packet_done,
	input wire logic frame_sent_ack_expected,
	input wire logic ack_received,
	input wire logic [3:0] slot_number,
	// RF front end and MAC status outputs
	output logic tx_enable,
	output logic amp_enable,
	output logic packet_start,
	output logic ack_waiting,
	output logic ack_timeout,
	output logic ack_frame_pending,
	output logic symbol_strobe,
	output logic cap_active,
	output logic first_slot_active,
	output logic beacon_enabled,
	output logic buffer_enable
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// True when the byte address hits the aligned word of a register index
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] index);
		reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == index[ADDR_W-3:0]);
	endfunction

	mac_tx_timing_pkg::timing_config_t cfg;
	mac_tx_timing_pkg::lead_state_t lead_state;
	logic [7:0] next_readdata;
	logic [3:0] tick_div;
	logic [8:0] tick_count;
	logic [6:0] ack_count;
	logic [mac_tx_timing_pkg::LEAD_W-1:0] lead_remaining;
	logic [mac_tx_timing_pkg::LEAD_W-1:0] tx_total;
	logic [mac_tx_timing_pkg::LEAD_W-1:0] amp_total;

	// Bus strobes: access completes on the edge where waitrequest is low
	wire bus_req = read | write;
	wire wr_fire = clk_en & write & ~waitrequest & byteenable[0];
	wire [7:0] wbyte = writedata[7:0];
	wire hit_order = reg_hit(address, mac_tx_timing_pkg::IDX_ORDER);
	wire hit_ack = reg_hit(address, mac_tx_timing_pkg::IDX_ACK_WAIT_CONTROL);
	wire hit_slot = reg_hit(address, mac_tx_timing_pkg::IDX_FIRST_SLOT_END_CAP_END_SLOT);
	wire hit_tlow = reg_hit(address, mac_tx_timing_pkg::IDX_SYMBOL_TICK_LOW);
	wire hit_thigh = reg_hit(address, mac_tx_timing_pkg::IDX_SYMBOL_TICK_HIGH_TX_LEAD);
	wire hit_alow = reg_hit(address, mac_tx_timing_pkg::IDX_AMP_LEAD_TICK_LOW);
	wire hit_asym = reg_hit(address, mac_tx_timing_pkg::IDX_AMP_LEAD_SYMBOLS);
	wire hit_txc = reg_hit(address, mac_tx_timing_pkg::IDX_TX_LEAD_FIFO_CONTROL);

	// Read multiplexer; unmapped addresses and reserved bits read as zero
	always_comb begin
		if (hit_order) begin
			next_readdata = {cfg.beacon_interval_order, cfg.superframe_order};
		end else if (hit_ack) begin
			next_readdata = {cfg.data_request_pending_flag, cfg.ack_wait_symbols};
		end else if (hit_slot) begin
			next_readdata = {cfg.first_slot_end, cfg.contention_period_end};
		end else if (hit_tlow) begin
			next_readdata = cfg.symbol_tick_count[7:0];
		end else if (hit_thigh) begin
			next_readdata = {cfg.tx_lead_ticks[6:0], cfg.symbol_tick_count[8]};
		end else if (hit_alow) begin
			next_readdata = cfg.amp_lead_ticks[7:0];
		end else if (hit_asym) begin
			next_readdata = {3'h0, cfg.amp_lead_symbol_count, cfg.amp_lead_ticks[8]};
		end else if (hit_txc) begin
			next_readdata = {cfg.buffer_enable_keep_high, 1'b0, cfg.tx_lead_symbols,
				cfg.tx_lead_ticks[8:7]};
		end else begin
			next_readdata = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------

	// One wait cycle per access, then waitrequest drops for exactly one edge
	// Read data is captured on the wait cycle so it already stands at the completing edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			waitrequest <= ~(bus_req & waitrequest);
			if (read && waitrequest) begin
				readdata <= {24'h00_0000, next_readdata};
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------

	// Register writes; reserved bits are not stored
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg.data_request_pending_flag <= 1'b0;
			cfg.ack_wait_symbols <= mac_tx_timing_pkg::RST_ACK_WAIT_SYMBOLS;
			cfg.first_slot_end <= 4'h0;
			cfg.contention_period_end <= 4'h0;
			cfg.symbol_tick_count <= mac_tx_timing_pkg::RST_SYMBOL_TICK_COUNT;
			cfg.tx_lead_ticks <= mac_tx_timing_pkg::RST_TX_LEAD_TICKS;
			cfg.tx_lead_symbols <= mac_tx_timing_pkg::RST_TX_LEAD_SYMBOLS;
			cfg.amp_lead_ticks <= mac_tx_timing_pkg::RST_AMP_LEAD_TICKS;
			cfg.amp_lead_symbol_count <= mac_tx_timing_pkg::RST_AMP_LEAD_SYMBOLS;
			cfg.buffer_enable_keep_high <= 1'b1;
			cfg.beacon_interval_order <= mac_tx_timing_pkg::RST_ORDER;
			cfg.superframe_order <= mac_tx_timing_pkg::RST_ORDER;
		end else if (wr_fire) begin
			if (hit_order) begin
				cfg.beacon_interval_order <= wbyte[7:4];
				cfg.superframe_order <= wbyte[3:0];
			end
			if (hit_ack) begin
				cfg.data_request_pending_flag <= wbyte[mac_tx_timing_pkg::PENDING_BIT];
				cfg.ack_wait_symbols <= wbyte[6:0];
			end
			if (hit_slot) begin
				cfg.first_slot_end <= wbyte[mac_tx_timing_pkg::NIBBLE_HIGH_LSB +: 4];
				cfg.contention_period_end <= wbyte[3:0];
			end
			if (hit_tlow) begin
				cfg.symbol_tick_count[7:0] <= wbyte;
			end
			if (hit_thigh) begin
				cfg.symbol_tick_count[8] <= wbyte[0];
				cfg.tx_lead_ticks[6:0] <= wbyte[mac_tx_timing_pkg::TX_LEAD_LOW_LSB +: 7];
			end
			if (hit_alow) begin
				cfg.amp_lead_ticks[7:0] <= wbyte;
			end
			if (hit_asym) begin
				cfg.amp_lead_ticks[8] <= wbyte[0];
				cfg.amp_lead_symbol_count <= wbyte[mac_tx_timing_pkg::AMP_SYMBOLS_LSB +: 4];
			end
			if (hit_txc) begin
				cfg.buffer_enable_keep_high <= wbyte[mac_tx_timing_pkg::BUFFER_ENABLE_BIT];
				cfg.tx_lead_symbols <= wbyte[mac_tx_timing_pkg::TX_SYMBOLS_LSB +: 4];
				cfg.tx_lead_ticks[8:7] <= wbyte[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Tick and symbol timing
	// ----------------------------------------------------------------

	// A tick is one 50 ns step, two core clocks at 40 MHz
	wire tick_en = (tick_div == 4'(mac_tx_timing_pkg::TICK_CYCLES - 1));
	// A zero period is treated as one tick so the strobe never stops
	wire sym_hit = tick_en && (tick_count >= cfg.symbol_tick_count - 9'h001 ||
		cfg.symbol_tick_count == 9'h000);

	// Tick prescaler and symbol period counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_div <= 4'h0;
			tick_count <= 9'h000;
			symbol_strobe <= 1'b0;
		end else if (clk_en) begin
			tick_div <= tick_en ? 4'h0 : tick_div + 4'h1;
			if (sym_hit) begin
				tick_count <= 9'h000;
			end else if (tick_en) begin
				tick_count <= tick_count + 9'h001;
			end
			symbol_strobe <= sym_hit;
		end
	end

	// ----------------------------------------------------------------
	// Acknowledgement wait timer
	// ----------------------------------------------------------------

	// Counts symbol strobes after a frame that expects an ack; ack arrival wins
	// A restart clears the count, so strobes of an earlier frame are not carried over
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_waiting <= 1'b0;
			ack_count <= 7'h00;
			ack_timeout <= 1'b0;
		end else if (clk_en) begin
			ack_timeout <= 1'b0;
			if (frame_sent_ack_expected) begin
				ack_waiting <= 1'b1;
				ack_count <= 7'h00;
			end else if (ack_received) begin
				ack_waiting <= 1'b0;
			end else if (ack_waiting && sym_hit) begin
				if (ack_count + 7'h01 >= cfg.ack_wait_symbols) begin
					ack_waiting <= 1'b0;
					ack_timeout <= 1'b1;
				end else begin
					ack_count <= ack_count + 7'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Superframe slot decode and static outputs
	// ----------------------------------------------------------------

	// No active period when either order field reads all ones
	// Contention slots come first; the first guaranteed slot window follows them
	wire beacon_on = (cfg.beacon_interval_order != mac_tx_timing_pkg::ORDER_NONE);
	wire active_on = beacon_on && (cfg.superframe_order != mac_tx_timing_pkg::ORDER_NONE);
	wire in_cap = (slot_number <= cfg.contention_period_end);
	wire in_first = (slot_number > cfg.contention_period_end) &&
		(slot_number <= cfg.first_slot_end);

	// Registered slot and configuration outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap_active <= 1'b0;
			first_slot_active <= 1'b0;
			beacon_enabled <= 1'b0;
			ack_frame_pending <= 1'b0;
			buffer_enable <= 1'b1;
		end else if (clk_en) begin
			cap_active <= active_on && in_cap;
			first_slot_active <= active_on && in_first;
			beacon_enabled <= beacon_on;
			ack_frame_pending <= cfg.data_request_pending_flag;
			buffer_enable <= cfg.buffer_enable_keep_high;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter and amplifier lead sequencing
	// ----------------------------------------------------------------

	// Total lead in ticks: symbols times the symbol period plus fine ticks
	// Operands are widened before the product so no high bits are lost;
	// fifteen symbols of the longest period plus the tick field still fit
	wire [mac_tx_timing_pkg::LEAD_W-1:0] period_w = mac_tx_timing_pkg::LEAD_W'(cfg.symbol_tick_count);
	wire [mac_tx_timing_pkg::LEAD_W-1:0] tx_symbols_w = mac_tx_timing_pkg::LEAD_W'(cfg.tx_lead_symbols);
	wire [mac_tx_timing_pkg::LEAD_W-1:0] amp_symbols_w =
		mac_tx_timing_pkg::LEAD_W'(cfg.amp_lead_symbol_count);
	assign tx_total = tx_symbols_w * period_w
		+ mac_tx_timing_pkg::LEAD_W'(cfg.tx_lead_ticks);
	assign amp_total = amp_symbols_w * period_w
		+ mac_tx_timing_pkg::LEAD_W'(cfg.amp_lead_ticks);
	wire [mac_tx_timing_pkg::LEAD_W-1:0] lead_max = (tx_total > amp_total) ? tx_total : amp_total;
	wire [mac_tx_timing_pkg::LEAD_W-1:0] lead_dec = lead_remaining - 14'h0001;

	// Countdown to packet start; each enable rises when its lead remains
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lead_state <= mac_tx_timing_pkg::LEAD_IDLE;
			lead_remaining <= 14'h0000;
			tx_enable <= 1'b0;
			amp_enable <= 1'b0;
			packet_start <= 1'b0;
		end else if (clk_en) begin
			packet_start <= 1'b0;
			case (lead_state)
				mac_tx_timing_pkg::LEAD_IDLE: begin
					if (tx_request) begin
						lead_remaining <= lead_max;
						tx_enable <= (tx_total >= lead_max);
						amp_enable <= (amp_total >= lead_max);
						lead_state <= mac_tx_timing_pkg::LEAD_COUNT;
					end
				end
				mac_tx_timing_pkg::LEAD_COUNT: begin
					if (lead_remaining == 14'h0000) begin
						packet_start <= 1'b1;
						tx_enable <= 1'b1;
						amp_enable <= 1'b1;
						lead_state <= mac_tx_timing_pkg::LEAD_SEND;
					end else if (tick_en) begin
						lead_remaining <= lead_dec;
						if (lead_dec <= tx_total) begin
							tx_enable <= 1'b1;
						end
						if (lead_dec <= amp_total) begin
							amp_enable <= 1'b1;
						end
					end
				end
				mac_tx_timing_pkg::LEAD_SEND: begin
					if (packet_done) begin
						tx_enable <= 1'b0;
						amp_enable <= 1'b0;
						lead_state <= mac_tx_timing_pkg::LEAD_IDLE;
					end
				end
				default: begin
					lead_state <= mac_tx_timing_pkg::LEAD_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### src/mac_tx_timing_pkg.sv
// Package for the MAC transmit timing configuration block.
// Holds register indices, field positions, reset values, timing constants and the config carrier.
// Assumes a 40 MHz core clock and a 32-bit Avalon-MM register bus.
package mac_tx_timing_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_ORDER = 8'h10;
	localparam logic [7:0] IDX_ACK_WAIT_CONTROL = 8'h12;
	localparam logic [7:0] IDX_FIRST_SLOT_END_CAP_END_SLOT = 8'h13;
	localparam logic [7:0] IDX_SYMBOL_TICK_LOW = 8'h14;
	localparam logic [7:0] IDX_SYMBOL_TICK_HIGH_TX_LEAD = 8'h15;
	localparam logic [7:0] IDX_AMP_LEAD_TICK_LOW = 8'h16;
	localparam logic [7:0] IDX_AMP_LEAD_SYMBOLS = 8'h17;
	localparam logic [7:0] IDX_TX_LEAD_FIFO_CONTROL = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PENDING_BIT = 7;
	localparam int TX_LEAD_LOW_LSB = 1;
	localparam int AMP_SYMBOLS_LSB = 1;
	localparam int TX_SYMBOLS_LSB = 2;
	localparam int BUFFER_ENABLE_BIT = 7;
	localparam int NIBBLE_HIGH_LSB = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] RST_ACK_WAIT_SYMBOLS = 7'h39;
	localparam logic [8:0] RST_SYMBOL_TICK_COUNT = 9'h140;
	localparam logic [8:0] RST_TX_LEAD_TICKS = 9'h028;
	localparam logic [8:0] RST_AMP_LEAD_TICKS = 9'h029;
	localparam logic [3:0] RST_AMP_LEAD_SYMBOLS = 4'h1;
	localparam logic [3:0] RST_TX_LEAD_SYMBOLS = 4'h2;
	localparam logic [3:0] RST_ORDER = 4'hF;
	localparam logic [3:0] ORDER_NONE = 4'hF;

	// ----------------------------------------------------------------
	// Timing: one tick is 50 ns, clock period 25 ns
	// ----------------------------------------------------------------
	localparam int TICK_PERIOD_NS = 50;
	localparam int CLOCK_PERIOD_PS = 25000;
	localparam int TICK_CYCLES_RAW = (TICK_PERIOD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int TICK_CYCLES = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
	localparam int LEAD_W = 14;

	// ----------------------------------------------------------------
	// Configuration carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic data_request_pending_flag;
		logic [6:0] ack_wait_symbols;
		logic [3:0] first_slot_end;
		logic [3:0] contention_period_end;
		logic [8:0] symbol_tick_count;
		logic [8:0] tx_lead_ticks;
		logic [3:0] tx_lead_symbols;
		logic [8:0] amp_lead_ticks;
		logic [3:0] amp_lead_symbol_count;
		logic buffer_enable_keep_high;
		logic [3:0] beacon_interval_order;
		logic [3:0] superframe_order;
	} timing_config_t;

	typedef enum logic [1:0] {
		LEAD_IDLE,
		LEAD_COUNT,
		LEAD_SEND
	} lead_state_t;

endpackage

// ### test/mac_tx_timing_config_assertions.sv
// Port-level checks for the MAC transmit timing configuration block.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module mac_tx_timing_config_assertions #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Sequencing and front end
	input wire logic packet_done,
	input wire logic frame_sent_ack_expected,
	input wire logic tx_enable,
	input wire logic amp_enable,
	input wire logic packet_start,
	input wire logic ack_waiting,
	input wire logic ack_timeout,
	input wire logic ack_frame_pending,
	input wire logic symbol_strobe
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_bus_one_wait: assert property ((read || write) && waitrequest && clk_en |=> !waitrequest)
		else $error("bus access not answered after one wait cycle");
	a_bus_low_once: assert property (!waitrequest && clk_en |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_pending_bit: assert property (write && !waitrequest && byteenable[0]
		&& address == ADDR_W'(8'h48) |-> ##2 ack_frame_pending == $past(writedata[7], 2))
		else $error("frame pending level does not follow written bit");
	a_strobe_pulse: assert property (symbol_strobe |=> !symbol_strobe)
		else $error("symbol strobe longer than one cycle");
	a_timeout_cause: assert property (ack_timeout |-> symbol_strobe && !ack_waiting
		&& $past(ack_waiting))
		else $error("ack timeout without running timer or strobe");
	a_wait_start: assert property (frame_sent_ack_expected && clk_en |=> ack_waiting)
		else $error("ack timer not started");
	a_start_enables: assert property (packet_start |-> tx_enable && amp_enable ##1 !packet_start)
		else $error("packet start without both enables or too long");
	a_tx_hold: assert property (tx_enable && !packet_done && clk_en |=> tx_enable)
		else $error("transmitter enable dropped before packet done");
	a_amp_hold: assert property (amp_enable && !packet_done && clk_en |=> amp_enable)
		else $error("amplifier enable dropped before packet done");
endmodule

bind mac_tx_timing_config mac_tx_timing_config_assertions #(.ADDR_W(ADDR_W)) i_checker (
	.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .packet_done(packet_done),
	.frame_sent_ack_expected(frame_sent_ack_expected), .tx_enable(tx_enable),
	.amp_enable(amp_enable), .packet_start(packet_start), .ack_waiting(ack_waiting),
	.ack_timeout(ack_timeout), .ack_frame_pending(ack_frame_pending),
	.symbol_strobe(symbol_strobe)
);
`default_nettype wire

// ### test/rf_front_end_model.sv
// Behavioural RF front end: ends each packet after a set air time.
// Assumes the block raises packet_start with both enables on.
`timescale 1ns/1ps
`default_nettype none
module rf_front_end_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Enables from the block
	input wire logic tx_enable,
	input wire logic amp_enable,
	input wire logic packet_start,
	// Air time and results
	input wire logic [7:0] air_cycles,
	output logic packet_done,
	output logic start_fault
);
	logic [7:0] left;
	// Counts air time; flags a packet sent without both enables held on
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left <= 8'h00;
			packet_done <= 1'h0;
			start_fault <= 1'h0;
		end else begin
			packet_done <= 1'h0;
			if (packet_start) begin
				left <= air_cycles;
			end else if (left != 8'h00) begin
				left <= left - 8'h01;
				packet_done <= (left == 8'h01);
			end
			if ((packet_start || left != 8'h00) && !(tx_enable && amp_enable)) begin
				start_fault <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/mac_tx_timing_config_tb.sv
// Self-checking bench for the MAC transmit timing configuration block.
// Assumes the front end model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module mac_tx_timing_config_tb;
	typedef struct {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_t;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic read = 1'h0;
	logic write = 1'h0;
	logic clk_en = 1'h1;
	logic tx_request = 1'h0;
	logic frame_sent_ack_expected = 1'h0;
	logic ack_received = 1'h0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [3:0] slot_number = 4'h0;
	logic [31:0] readdata;
	logic waitrequest, tx_enable, amp_enable, packet_start, packet_done, ack_waiting;
	logic ack_timeout, ack_frame_pending, symbol_strobe, cap_active, first_slot_active;
	logic beacon_enabled, buffer_enable, start_fault;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// Register rows: reset values first, then writes read back
	row_t rows [16] = '{'{1'h0, 8'h10, 8'h00, 8'hFF}, '{1'h0, 8'h12, 8'h00, 8'h39},
		'{1'h0, 8'h13, 8'h00, 8'h00}, '{1'h0, 8'h14, 8'h00, 8'h40}, '{1'h0, 8'h15, 8'h00, 8'h51},
		'{1'h0, 8'h16, 8'h00, 8'h29}, '{1'h0, 8'h17, 8'h00, 8'h02}, '{1'h0, 8'h18, 8'h00, 8'h88},
		'{1'h1, 8'h12, 8'h83, 8'h83}, '{1'h1, 8'h13, 8'h73, 8'h73}, '{1'h1, 8'h16, 8'h01, 8'h01},
		'{1'h1, 8'h17, 8'h04, 8'h04}, '{1'h1, 8'h18, 8'h84, 8'h84}, '{1'h1, 8'h10, 8'h44, 8'h44},
		'{1'h1, 8'h19, 8'h55, 8'h00}, '{1'h1, 8'h11, 8'h66, 8'h00}};

	always #12.5 clock = ~clock;

	mac_tx_timing_config i_mac_tx_timing_config (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.tx_request(tx_request), .packet_done(packet_done),
		.frame_sent_ack_expected(frame_sent_ack_expected), .ack_received(ack_received),
		.slot_number(slot_number), .tx_enable(tx_enable), .amp_enable(amp_enable),
		.packet_start(packet_start), .ack_waiting(ack_waiting), .ack_timeout(ack_timeout),
		.ack_frame_pending(ack_frame_pending), .symbol_strobe(symbol_strobe),
		.cap_active(cap_active), .first_slot_active(first_slot_active),
		.beacon_enabled(beacon_enabled), .buffer_enable(buffer_enable));
	rf_front_end_model i_rf_front_end_model (.clock(clock), .rst_n(rst_n), .tx_enable(tx_enable),
		.amp_enable(amp_enable), .packet_start(packet_start), .air_cycles(8'h0A),
		.packet_done(packet_done), .start_fault(start_fault));

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("wrong value %s expected %0d to %0d seen %0d", name, lo, hi, got);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] be, output logic [31:0] rd);
		address <= {idx[5:0], 2'h0};
		read <= ~w;
		write <= w;
		writedata <= {24'h0, wd};
		byteenable <= be;
		do @(posedge clock); while (waitrequest !== 1'h0);
		rd = readdata;
		read <= 1'h0;
		write <= 1'h0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'h1, idx, wd, 4'hF, d);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		bus(1'h0, idx, 8'h00, 4'hF, d);
		chk($sformatf("register %h", idx), {24'h0, exp}, d);
	endtask
	task automatic wait_strobe();
		do @(posedge clock); while (symbol_strobe !== 1'h1);
	endtask
	task automatic period(input int exp);
		int n;
		wait_strobe();
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (symbol_strobe !== 1'h1);
		chk_rng("symbol period", exp, exp, n);
	endtask
	// Runs one lead sequence; t and a are totals in 50 ns ticks
	task automatic lead_run(input int t, input int a);
		int m, nt, na, ps, n;
		m = (t > a) ? t : a;
		nt = 0;
		na = 0;
		ps = 0;
		tx_request <= 1'h1;
		for (n = 1; n < 700 && ps == 0; n++) begin
			@(posedge clock);
			tx_request <= 1'h0;
			#1;
			if (tx_enable === 1'h1 && nt == 0) nt = n;
			if (amp_enable === 1'h1 && na == 0) na = n;
			if (packet_start === 1'h1) ps = n;
		end
		chk_rng("packet start", 2 * m + 1, 2 * m + 2, ps);
		chk_rng("tx lead", 2 * (m - t), 2 * (m - t) + 2, nt);
		chk_rng("amp lead", 2 * (m - a), 2 * (m - a) + 2, na);
		for (n = 0; n < 50 && tx_enable !== 1'h0; n++) @(posedge clock);
		#1;
		chk("enables off", 32'h0, {30'h0, tx_enable, amp_enable});
		chk("front end fault", 32'h0, {31'h0, start_fault});
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] d;
		int n;
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		chk("buffer enable", 32'h1, {31'h0, buffer_enable});
		chk("beacon off", 32'h0, {31'h0, beacon_enabled});
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
			rd_chk(rows[i].idx, rows[i].exp);
		end
		chk("pending set", 32'h1, {31'h0, ack_frame_pending});
		bus(1'h1, 8'h13, 8'h00, 4'hE, d);
		rd_chk(8'h13, 8'h73);
		// Slot windows: contention up to 3, first slot 4 to 7
		for (n = 0; n < 16; n++) begin
			slot_number <= 4'(n);
			repeat (2) @(posedge clock);
			#1;
			chk("cap active", {31'h0, n <= 3}, {31'h0, cap_active});
			chk("first slot", {31'h0, n > 3 && n <= 7}, {31'h0, first_slot_active});
		end
		chk("beacon on", 32'h1, {31'h0, beacon_enabled});
		// Beacon on but superframe order all ones: no contention window at all
		wr(8'h10, 8'h4F);
		slot_number <= 4'h0;
		repeat (2) @(posedge clock);
		#1;
		chk("no active period", 32'h0, {31'h0, cap_active});
		period(640);
		wr(8'h14, 8'h00);
		period(512);
		wr(8'h14, 8'h04);
		wr(8'h15, 8'h04);
		period(8);
		// Clock enable low freezes the tick counter, then it runs on as before
		wait_strobe();
		clk_en <= 1'h0;
		n = 0;
		repeat (24) begin
			@(posedge clock);
			if (symbol_strobe === 1'h1) n++;
		end
		clk_en <= 1'h1;
		chk_rng("frozen strobes", 0, 0, n);
		period(8);
		lead_run(6, 9);
		wr(8'h18, 8'h8D);
		wr(8'h15, 8'h00);
		wr(8'h17, 8'h03);
		wr(8'h16, 8'h00);
		lead_run(140, 260);
		wr(8'h12, 8'h03);
		@(posedge clock);
		chk("pending clear", 32'h0, {31'h0, ack_frame_pending});
		// Timeout on the third strobe, then a timer stopped by an ack
		wait_strobe();
		frame_sent_ack_expected <= 1'h1;
		@(posedge clock);
		frame_sent_ack_expected <= 1'h0;
		n = 0;
		do begin
			@(posedge clock);
			if (symbol_strobe === 1'h1) n++;
		end while (ack_timeout !== 1'h1 && n < 10);
		chk_rng("ack timeout strobes", 3, 3, n);
		wait_strobe();
		frame_sent_ack_expected <= 1'h1;
		@(posedge clock);
		frame_sent_ack_expected <= 1'h0;
		wait_strobe();
		ack_received <= 1'h1;
		@(posedge clock);
		ack_received <= 1'h0;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (ack_timeout === 1'h1) n++;
		end
		chk_rng("stopped timer", 0, 0, n);
		chk("ack waiting", 32'h0, {31'h0, ack_waiting});
		rst_n <= 1'h0;
		repeat (3) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		rd_chk(8'h12, 8'h39);
		rd_chk(8'h18, 8'h88);
		give_verdict();
	end
endmodule
`default_nettype wire
